// *** include/ifp_consts.vh ***
`ifndef IFP_CONSTS_VH
`define IFP_CONSTS_VH
// Register byte offsets
`define IFP_OFF_FLAG 12'h000
`define IFP_OFF_ENABLE 12'h004
`define IFP_OFF_PRIO0 12'h010
`define IFP_OFF_PRIO7 12'h02c
`define IFP_OFF_SHADOW 12'h030
`define IFP_OFF_CTRL 12'h034
`define IFP_OFF_RELOAD 12'h038
`define IFP_OFF_IRQ_STAT 12'h03c
`define IFP_OFF_IRQ_MASK 12'h040
`define IFP_OFF_WINNER 12'h044
`define IFP_OFF_VEC0 12'h400
`define IFP_OFF_VEC_LAST 12'h6f8
// Field positions
`define IFP_PRIO_MSB 4
`define IFP_PRIO_LSB 2
`define IFP_SUB_MSB 1
`define IFP_SUB_LSB 0
`define IFP_BYTE_MASK 8'h1f
`define IFP_VOFF_MASK 32'h0003fffe
`define IFP_CTRL_MULTI_VECTOR_SELECT 0
`define IFP_SS_RSVD 3
// Reset values
`define IFP_RST_WORD 32'h00000000
// Event bits of the interrupt status
`define IFP_EV_PEND 0
`define IFP_EV_WIN_CHG 1
`define IFP_EV_TIMER 2
`endif

// *** hdl/ifp_arbiter.v ***
`timescale 1ns/1ps
`include "ifp_consts.vh"
// Picks the pending source with the highest priority, then sub-priority
module ifp_arbiter #(
   parameter NSRC = 32
) (
   // Source state
   input wire [NSRC-1:0] flags_i,
   input wire [NSRC-1:0] enables_i,
   input wire [NSRC*5-1:0] levels_i,
   // Winner
   output reg valid_o,
   output reg [4:0] id_o,
   output reg [2:0] prio_o,
   output reg [1:0] sub_o
);
   integer i;
   reg [2:0] p;
   reg [1:0] s;
   // Lower index wins a full tie
   always @* begin
      valid_o = 1'b0;
      id_o = 5'h00;
      prio_o = 3'h0;
      sub_o = 2'h0;
      p = 3'h0;
      s = 2'h0;
      for (i = 0; i < NSRC; i = i + 1) begin
         p = levels_i[i*5+2 +: 3];
         s = levels_i[i*5 +: 2];
         if (flags_i[i] && enables_i[i] && p != 3'h0) begin
            if (!valid_o || p > prio_o || (p == prio_o && s > sub_o)) begin
               valid_o = 1'b1;
               id_o = i[4:0];
               prio_o = p;
               sub_o = s;
            end
         end
      end
   end
endmodule

// *** hdl/ifp_regs.v ***
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "ifp_consts.vh"
// Behaviour
// - A source request sets its flag bit, which stays set until cleared.
// - A source may request the core only while its enable bit is one; any request sets the pending event.
// - Priority 001..111 is level one to seven; 000 disables the source.
// - Two-bit sub-priority 0..3 ranks sources sharing one priority level.
// - Four sources per priority word; byte holds priority 4:2, sub 1:0.
// - Upper sources repeat the byte layout; top source at 28:26, 25:24.
// - One offset register per vector 0..190, offset held in bits 17:1.
// - Bit zero of each offset register reads zero, forcing even offsets.
// - Each level selects shadow set via four bits; codes 1xxx mean set zero.
// - Reload register supplies value loaded when a qualifying event starts the timer.
module ifp_regs #(
   parameter NSRC = 32,
   parameter NVEC = 191
) (
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // AHB-Lite slave
   input wire hsel_i,
   input wire [11:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output reg [31:0] hrdata_o,
   output reg hreadyout_o,
   output reg hresp_o,
   // Interrupt sources, same clock
   input wire [NSRC-1:0] src_req_i,
   // Core side
   output reg core_req_o,
   output reg [4:0] core_id_o,
   output reg [2:0] core_prio_o,
   output reg [2:0] core_shadow_o,
   output reg [31:0] core_offset_o,
   output reg [31:0] prox_reload_o,
   output reg prox_load_o,
   output reg irq_o
);
   reg [NSRC-1:0] source_request_flags_reg;
   reg [NSRC-1:0] source_enable_bits_reg;
   reg [31:0] prio_reg [0:7];
   reg [31:0] handler_offset_field_reg [0:NVEC-1];
   reg [31:0] shadow_reg;
   reg multi_vector_select_reg;
   reg [31:0] proximity_reload_value_reg;
   reg [2:0] irq_stat_reg;
   reg [2:0] irq_mask_reg;
   reg [4:0] win_id_reg;
   reg win_valid_reg;
   reg [2:0] win_prio_reg;
   reg [1:0] win_sub_reg;
   reg wr_pend_reg;
   reg [11:0] wr_addr_reg;
   reg [NSRC*5-1:0] levels;
   reg [2:0] irq_stat_next;
   reg [31:0] rd_word;
   wire arb_valid;
   wire [4:0] arb_id;
   wire [2:0] arb_prio;
   wire [1:0] arb_sub;
   wire [3:0] ss_code;
   wire addr_ok;
   wire [NSRC-1:0] wr_flag_bits;
   integer k;
   integer j;
   integer m;

   // Byte-masked priority word
   function [31:0] prio_mask;
      input [31:0] w;
      begin
         prio_mask = w & {4{`IFP_BYTE_MASK}};
      end
   endfunction

   // Vector register index from byte address
   function [7:0] vec_index;
      input [11:0] a;
      reg [11:0] d;
      begin
         d = a - `IFP_OFF_VEC0;
         vec_index = d[9:2];
      end
   endfunction

   // Address falls inside the priority word range
   function in_prio;
      input [11:0] a;
      begin
         in_prio = (a >= `IFP_OFF_PRIO0) && (a <= `IFP_OFF_PRIO7);
      end
   endfunction

   // Address falls inside the vector offset table
   function in_vec;
      input [11:0] a;
      begin
         in_vec = (a >= `IFP_OFF_VEC0) && (a <= `IFP_OFF_VEC_LAST);
      end
   endfunction

   // Priority word index from byte address
   function [2:0] prio_index;
      input [11:0] a;
      reg [11:0] d;
      begin
         d = a - `IFP_OFF_PRIO0;
         prio_index = d[4:2];
      end
   endfunction

   // Gather priority fields per source
   always @* begin
      levels = {NSRC*5{1'b0}};
      for (k = 0; k < NSRC; k = k + 1) begin
         levels[k*5 +: 5] = prio_reg[k/4][(k%4)*8 +: 5];
      end
   end

   ifp_arbiter #(
      .NSRC(NSRC)
   ) u_arb (
      .flags_i(source_request_flags_reg),
      .enables_i(source_enable_bits_reg),
      .levels_i(levels),
      .valid_o(arb_valid),
      .id_o(arb_id),
      .prio_o(arb_prio),
      .sub_o(arb_sub)
   );

   // Shadow set of the winning level; reserved codes fall back to set zero
   assign ss_code = shadow_reg[arb_prio*4 +: 4];

   // Address phase check
   assign addr_ok = hsel_i && hready_i && htrans_i[1];

   // Write-side flag update mask
   assign wr_flag_bits = (wr_pend_reg && wr_addr_reg == `IFP_OFF_FLAG) ?
                         hwdata_i[NSRC-1:0] : source_request_flags_reg;

   // Read mux
   always @* begin
      rd_word = `IFP_RST_WORD;
      if (haddr_i == `IFP_OFF_FLAG) begin
         rd_word = source_request_flags_reg;
      end else if (haddr_i == `IFP_OFF_ENABLE) begin
         rd_word = source_enable_bits_reg;
      end else if (in_prio(haddr_i)) begin
         rd_word = prio_reg[prio_index(haddr_i)];
      end else if (haddr_i == `IFP_OFF_SHADOW) begin
         rd_word = shadow_reg;
      end else if (haddr_i == `IFP_OFF_CTRL) begin
         rd_word = {31'h0, multi_vector_select_reg};
      end else if (haddr_i == `IFP_OFF_RELOAD) begin
         rd_word = proximity_reload_value_reg;
      end else if (haddr_i == `IFP_OFF_IRQ_STAT) begin
         rd_word = {29'h0, irq_stat_reg};
      end else if (haddr_i == `IFP_OFF_IRQ_MASK) begin
         rd_word = {29'h0, irq_mask_reg};
      end else if (haddr_i == `IFP_OFF_WINNER) begin
         rd_word = {21'h0, win_sub_reg, win_prio_reg, win_valid_reg, win_id_reg};
      end else if (in_vec(haddr_i)) begin
         rd_word = handler_offset_field_reg[vec_index(haddr_i)];
      end
   end

   // Interrupt status events; a new event beats a write-one clear
   always @* begin
      irq_stat_next = irq_stat_reg;
      if (wr_pend_reg && wr_addr_reg == `IFP_OFF_IRQ_STAT) begin
         irq_stat_next = irq_stat_reg & ~hwdata_i[2:0];
      end
      if (|src_req_i) begin
         irq_stat_next[`IFP_EV_PEND] = 1'b1;
      end
      if (arb_valid != win_valid_reg || arb_id != win_id_reg) begin
         irq_stat_next[`IFP_EV_WIN_CHG] = 1'b1;
      end
      if (arb_valid && !win_valid_reg) begin
         irq_stat_next[`IFP_EV_TIMER] = 1'b1;
      end
   end

   // Bus handshake; no wait states, read data stands in the data phase
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
         hrdata_o <= `IFP_RST_WORD;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hresp_o <= 1'b0;
         hreadyout_o <= 1'b1;
         wr_pend_reg <= addr_ok && hwrite_i;
         wr_addr_reg <= haddr_i;
         if (addr_ok && !hwrite_i) begin
            hrdata_o <= rd_word;
         end
      end
   end

   // Requests set flags; set wins over software clear
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         source_request_flags_reg <= {NSRC{1'b0}};
         irq_stat_reg <= 3'h0;
      end else begin
         source_request_flags_reg <= wr_flag_bits | src_req_i;
         irq_stat_reg <= irq_stat_next;
      end
   end

   // Control registers, committed at the end of the data phase
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         source_enable_bits_reg <= {NSRC{1'b0}};
         for (j = 0; j < 8; j = j + 1) begin
            prio_reg[j] <= `IFP_RST_WORD;
         end
         shadow_reg <= `IFP_RST_WORD;
         multi_vector_select_reg <= 1'b0;
         proximity_reload_value_reg <= `IFP_RST_WORD;
         irq_mask_reg <= 3'h0;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == `IFP_OFF_ENABLE) begin
            source_enable_bits_reg <= hwdata_i[NSRC-1:0];
         end
         if (in_prio(wr_addr_reg)) begin
            prio_reg[prio_index(wr_addr_reg)] <= prio_mask(hwdata_i);
         end
         if (wr_addr_reg == `IFP_OFF_SHADOW) begin
            shadow_reg <= hwdata_i;
         end
         if (wr_addr_reg == `IFP_OFF_CTRL) begin
            multi_vector_select_reg <= hwdata_i[`IFP_CTRL_MULTI_VECTOR_SELECT];
         end
         if (wr_addr_reg == `IFP_OFF_RELOAD) begin
            proximity_reload_value_reg <= hwdata_i;
         end
         if (wr_addr_reg == `IFP_OFF_IRQ_MASK) begin
            irq_mask_reg <= hwdata_i[2:0];
         end
      end
   end

   // Vector offset table; bit zero and bits above 17 never store
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (m = 0; m < NVEC; m = m + 1) begin
            handler_offset_field_reg[m] <= `IFP_RST_WORD;
         end
      end else if (wr_pend_reg && in_vec(wr_addr_reg)) begin
         handler_offset_field_reg[vec_index(wr_addr_reg)] <=
            hwdata_i & `IFP_VOFF_MASK;
      end
   end

   // Core-side outputs
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         core_req_o <= 1'b0;
         core_id_o <= 5'h00;
         core_prio_o <= 3'h0;
         core_shadow_o <= 3'h0;
         core_offset_o <= `IFP_RST_WORD;
         prox_reload_o <= `IFP_RST_WORD;
         prox_load_o <= 1'b0;
         irq_o <= 1'b0;
         win_id_reg <= 5'h00;
         win_valid_reg <= 1'b0;
         win_prio_reg <= 3'h0;
         win_sub_reg <= 2'h0;
      end else begin
         win_id_reg <= arb_id;
         win_valid_reg <= arb_valid;
         win_prio_reg <= arb_prio;
         win_sub_reg <= arb_sub;
         core_req_o <= arb_valid;
         core_id_o <= arb_id;
         core_prio_o <= arb_prio;
         core_offset_o <= handler_offset_field_reg[arb_id];
         // Shadow select only in multi-vector mode
         if (!multi_vector_select_reg || ss_code[`IFP_SS_RSVD]) begin
            core_shadow_o <= 3'h0;
         end else begin
            core_shadow_o <= ss_code[2:0];
         end
         prox_reload_o <= proximity_reload_value_reg;
         prox_load_o <= arb_valid && !win_valid_reg;
         irq_o <= |(irq_stat_next & irq_mask_reg);
      end
   end
endmodule

// *** test/ifp_core_model.sv ***
`timescale 1ns/1ps
// Core side: takes the source offered when a winner appears after none
module ifp_core_model (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Offer from the controller
   input wire logic req_i,
   input wire logic load_i,
   input wire logic [4:0] id_i,
   // Last source taken
   output logic [4:0] taken_id_o
);
   // Accept only while the request is raised
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         taken_id_o <= 5'h0;
      end else if (req_i && load_i) begin
         taken_id_o <= id_i;
      end
   end
endmodule

// *** test/ifp_regs_monitor.sv ***
`timescale 1ns/1ps
`include "ifp_consts.vh"
// Port checks of the priority and offset registers, an unmapped read at 0x048, core request, load pulse and bus response
module ifp_regs_monitor (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Bus
   input wire logic hsel_i,
   input wire logic [11:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hresp_o,
   // Core side
   input wire logic core_req_o,
   input wire logic [2:0] core_prio_o,
   input wire logic prox_load_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic [2:0] wr_age;
   wire take = hsel_i & hready_i & htrans_i[1];
   // Cycles since a bus write was taken, saturating
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_age <= 3'h7;
      end else if (take && hwrite_i) begin
         wr_age <= 3'h0;
      end else if (wr_age != 3'h7) begin
         wr_age <= wr_age + 3'h1;
      end
   end
   sequence rd_vec;
      take && !hwrite_i && haddr_i >= `IFP_OFF_VEC0 && haddr_i <= `IFP_OFF_VEC_LAST;
   endsequence
   sequence rd_prio;
      take && !hwrite_i && haddr_i >= `IFP_OFF_PRIO0 && haddr_i <= `IFP_OFF_PRIO7;
   endsequence
   a_offset_bits_zero: assert property (
      rd_vec |=> (hrdata_o & ~32'h0003fffe) == 32'h0) else $error("offset read wide");
   a_prio_top_zero: assert property (
      rd_prio |=> (hrdata_o & ~32'h1f1f1f1f) == 32'h0) else $error("priority read wide");
   a_unmapped_reads_zero: assert property (
      take && !hwrite_i && haddr_i == 12'h048 |=> hrdata_o == 32'h0) else $error("unmapped");
   a_req_nonzero_prio: assert property (
      core_req_o |-> core_prio_o != 3'h0) else $error("request at priority zero");
   a_load_on_rise: assert property (
      $rose(core_req_o) |-> prox_load_o) else $error("no load on new winner");
   a_load_one_cycle: assert property (
      prox_load_o |-> core_req_o ##1 !prox_load_o) else $error("load pulse wrong");
   a_req_drop_write: assert property (
      $fell(core_req_o) |-> wr_age <= 3'h3) else $error("request fell without write");
   a_resp_okay: assert property (
      !hresp_o) else $error("error response");
endmodule
bind ifp_regs ifp_regs_monitor u_mon (.clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .hresp_o(hresp_o), .core_req_o(core_req_o),
   .core_prio_o(core_prio_o), .prox_load_o(prox_load_o));

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "ifp_consts.vh"
// Register, arbitration and interrupt checks over the bus
module tb;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] src = 32'h0;
   logic [31:0] hrdata, offset, reload, rd;
   logic hready, hresp, core_req, load, irq;
   logic [4:0] core_id, taken;
   logic [2:0] prio, shadow;
   int failures = 0;
   int comparisons = 0;
   int i;
   // Clock
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   ifp_regs DUT (.clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .src_req_i(src), .core_req_o(core_req), .core_id_o(core_id), .core_prio_o(prio),
      .core_shadow_o(shadow), .core_offset_o(offset), .prox_reload_o(reload),
      .prox_load_o(load), .irq_o(irq));
   ifp_core_model core (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(core_req),
      .load_i(load), .id_i(core_id), .taken_id_o(taken));
   task automatic finish_test;
      $display("Mismatches %0d, comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Next edge with ready high, bounded
   task automatic waitrdy;
      int k;
      k = 0;
      @(posedge clock_i);
      while (hready !== 1'b1 && k < 50) begin
         @(posedge clock_i);
         k++;
      end
      if (hready !== 1'b1) begin
         failures++;
         finish_test;
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      waitrdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitrdy;
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Let registered outputs settle
   task automatic wt;
      repeat (3) @(posedge clock_i);
      #1;
   endtask
   initial begin
      repeat (2) @(posedge clock_i);
      rstn_i <= 1'b1;
      wt;
      rdc(`IFP_OFF_FLAG, 32'h0);
      rdc(`IFP_OFF_ENABLE, 32'h0);
      rdc(`IFP_OFF_PRIO7, 32'h0);
      wr(`IFP_OFF_PRIO0, 32'hffffffff);
      rdc(`IFP_OFF_PRIO0, 32'h1f1f1f1f);
      wr(`IFP_OFF_VEC_LAST, 32'hffffffff);
      rdc(`IFP_OFF_VEC_LAST, 32'h0003fffe);
      wr(12'h048, 32'hffffffff);
      rdc(12'h048, 32'h0);
      // Sources 3 and 5 at priority 5, sub 1 and 3; source 8 at priority 0
      wr(`IFP_OFF_PRIO0, 32'h15000000);
      wr(12'h014, 32'h00001700);
      wr(12'h40c, 32'h00001235);
      wr(12'h414, 32'h00000a00);
      wr(`IFP_OFF_ENABLE, 32'hffffffff);
      wr(`IFP_OFF_CTRL, 32'h1);
      wr(`IFP_OFF_IRQ_MASK, 32'h4);
      @(posedge clock_i);
      src <= 32'h128;
      @(posedge clock_i);
      src <= 32'h0;
      wt;
      chk({27'h0, core_id}, 32'h5);
      chk({29'h0, prio}, 32'h5);
      chk(offset, 32'h00000a00);
      chk({27'h0, taken}, 32'h5);
      chk({31'h0, irq}, 32'h1);
      rdc(`IFP_OFF_FLAG, 32'h128);
      wr(`IFP_OFF_FLAG, 32'h108);
      wt;
      chk({27'h0, core_id}, 32'h3);
      chk(offset, 32'h00001234);
      rdc(`IFP_OFF_WINNER, 32'h00000363);
      for (i = 0; i < 16; i++) begin
         wr(`IFP_OFF_SHADOW, i << 20);
         wt;
         chk({29'h0, shadow}, (i < 8) ? i : 0);
      end
      wr(`IFP_OFF_SHADOW, 32'h00300000);
      wr(`IFP_OFF_CTRL, 32'h0);
      wt;
      chk({29'h0, shadow}, 32'h0);
      wr(`IFP_OFF_ENABLE, 32'hfffffff7);
      wt;
      chk({31'h0, core_req}, 32'h0);
      wr(`IFP_OFF_RELOAD, 32'ha5a5a5a5);
      wt;
      chk(reload, 32'ha5a5a5a5);
      wr(`IFP_OFF_IRQ_STAT, 32'h7);
      wt;
      chk({31'h0, irq}, 32'h0);
      rdc(`IFP_OFF_IRQ_STAT, 32'h0);
      wr(`IFP_OFF_ENABLE, 32'hffffffff);
      wt;
      chk({31'h0, irq}, 32'h1);
      wr(`IFP_OFF_IRQ_MASK, 32'h0);
      wt;
      chk({31'h0, irq}, 32'h0);
      finish_test;
   end
endmodule
